// ===== verilog/pcm_voice_port.sv
`default_nettype none
module pcm_voice_port
(
   // system clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // bit clock as seen at the pad, clocks the link logic
   input wire logic link_bclk,
   // stored configuration and connection enable
   input wire pcm_port_pkg::voice_cfg_t cfg_store,
   input wire logic voice_link_en,
   // baseband transmit samples
   input wire pcm_port_pkg::sample_t tx_data,
   input wire logic tx_valid,
   output var logic tx_ready,
   // baseband receive samples and status
   output var pcm_port_pkg::sample_t rx_data,
   output var logic rx_valid,
   output var logic slave_mode,
   // pads
   input wire logic pcm_in,
   output var logic pcm_out_o,
   output var logic pcm_out_oe_n,
   input wire logic pcm_sync_i,
   output var logic pcm_sync_o,
   output var logic pcm_sync_oe_n,
   output var logic pcm_clk_o,
   output var logic pcm_clk_oe_n
);
   localparam int unsigned PW = pcm_port_pkg::POS_W;

   // ***********************************************
   // configuration capture (reference domain)
   // ***********************************************
   pcm_port_pkg::voice_cfg_t cfg_m_q;
   pcm_port_pkg::voice_cfg_t cfg_s_q;
   pcm_port_pkg::voice_cfg_t cfg_q;
   logic [1:0] cfg_arm_q;
   logic cfg_taken_q;
   logic en_m_q;
   logic en_s_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_m_q <= pcm_port_pkg::CFG_RESET;
         cfg_s_q <= pcm_port_pkg::CFG_RESET;
         en_m_q <= 1'b0;
         en_s_q <= 1'b0;
      end
      else
      begin
         cfg_m_q <= cfg_store;
         cfg_s_q <= cfg_m_q;
         en_m_q <= voice_link_en;
         en_s_q <= en_m_q;
      end
   end

   // the stored value is taken once, after the synchroniser has filled
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_arm_q <= 2'h0;
         cfg_taken_q <= 1'b0;
         cfg_q <= pcm_port_pkg::CFG_RESET;
      end
      else
      begin
         cfg_arm_q <= {cfg_arm_q[0], 1'b1};
         if (cfg_arm_q[1] && !cfg_taken_q)
         begin
            cfg_q <= cfg_s_q;
            cfg_taken_q <= 1'b1;
         end
      end
   end

   assign slave_mode = cfg_q.slave;

   // ***********************************************
   // master clock and sync generation
   // ***********************************************
   logic [pcm_port_pkg::DIV_W-1:0] div_q;
   logic [pcm_port_pkg::FBIT_W-1:0] fbit_q;
   logic [pcm_port_pkg::FBIT_W-1:0] fbit_nx;
   logic clk_q;
   logic sync_q;
   logic gen_idle;

   assign gen_idle = cfg_q.slave || !cfg_taken_q;
   assign fbit_nx = (fbit_q == pcm_port_pkg::FBIT_LAST) ? '0 : fbit_q + 1'b1;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         div_q <= '0;
         clk_q <= 1'b0;
         fbit_q <= pcm_port_pkg::FBIT_LAST;
         sync_q <= 1'b0;
      end
      else if (gen_idle)
      begin
         div_q <= '0;
         clk_q <= 1'b0;
         fbit_q <= pcm_port_pkg::FBIT_LAST;
         sync_q <= 1'b0;
      end
      else if (div_q == pcm_port_pkg::DIV_LAST)
      begin
         div_q <= '0;
         clk_q <= ~clk_q;
         if (!clk_q)
         begin
            // sync moves with the rising edge, so it is launched like data
            fbit_q <= fbit_nx;
            sync_q <= (fbit_nx < pcm_port_pkg::SYNC_FALL_BIT);
         end
      end
      else
      begin
         div_q <= div_q + 1'b1;
      end
   end

   // pin direction follows the mode
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pcm_clk_oe_n <= 1'b0;
         pcm_sync_oe_n <= 1'b0;
      end
      else
      begin
         pcm_clk_oe_n <= cfg_q.slave;
         pcm_sync_oe_n <= cfg_q.slave;
      end
   end

   assign pcm_clk_o = clk_q;
   assign pcm_sync_o = sync_q;

   // ***********************************************
   // transmit buffer and handover
   // ***********************************************
   pcm_port_pkg::sample_t fifo_data;
   pcm_port_pkg::sample_t tx_hold_q;
   logic fifo_valid;
   logic tx_pop;
   logic tx_tgl_q;
   logic tx_tgl_m_q;
   logic tx_tgl_s_q;
   logic tx_tgl_p_q;

   sample_fifo #(
      .WIDTH(pcm_port_pkg::SAMPLE_W),
      .DEPTH(pcm_port_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(ref_clk),
      .rst(rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(tx_pop)
   );

   assign tx_pop = tx_tgl_s_q ^ tx_tgl_p_q;

   // the hold word is refilled right after the link took it, so it stays
   // stable for almost a whole frame before the link reads it again
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_tgl_m_q <= 1'b0;
         tx_tgl_s_q <= 1'b0;
         tx_tgl_p_q <= 1'b0;
         tx_hold_q <= '0;
      end
      else
      begin
         tx_tgl_m_q <= tx_tgl_q;
         tx_tgl_s_q <= tx_tgl_m_q;
         tx_tgl_p_q <= tx_tgl_s_q;
         // an empty buffer sends silence
         if (tx_pop)
            tx_hold_q <= fifo_valid ? fifo_data : '0;
      end
   end

   // ***********************************************
   // receive handover
   // ***********************************************
   pcm_port_pkg::sample_t rx_word_q;
   logic rx_tgl_q;
   logic rx_tgl_m_q;
   logic rx_tgl_s_q;
   logic rx_tgl_p_q;
   logic rx_edge;

   assign rx_edge = rx_tgl_s_q ^ rx_tgl_p_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_tgl_m_q <= 1'b0;
         rx_tgl_s_q <= 1'b0;
         rx_tgl_p_q <= 1'b0;
         rx_data <= '0;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_tgl_m_q <= rx_tgl_q;
         rx_tgl_s_q <= rx_tgl_m_q;
         rx_tgl_p_q <= rx_tgl_s_q;
         rx_valid <= rx_edge;
         if (rx_edge)
            rx_data <= rx_word_q;
      end
   end

   // ***********************************************
   // link domain: bit capture on falling edges
   // ***********************************************
   pcm_port_pkg::voice_cfg_t lcfg_m_q;
   pcm_port_pkg::voice_cfg_t lcfg_q;
   logic len_m_q;
   logic len_q;
   logic sync_prev_q;
   logic framed_q;
   logic have_len_q;
   logic [PW-1:0] pos_q;
   logic [PW-1:0] flen_q;
   logic [PW-1:0] cur;
   logic [PW-1:0] nxt;
   logic [PW-1:0] off;
   logic [PW-1:0] slen;
   logic start;
   logic in_rx;
   logic [15:0] rx_sh_q;
   logic [15:0] tx_sh_q;
   logic stage_oe_q;

   assign start = pcm_sync_i && !sync_prev_q;
   assign cur = start ? '0 : ((pos_q == '1) ? pos_q : pos_q + 1'b1);
   // the next frame start is predicted from the length of the last frame
   assign nxt = (have_len_q && (cur + 1'b1 == flen_q)) ? '0 : cur + 1'b1;
   assign off = pcm_port_pkg::slot_off(lcfg_q.slot_idx);
   assign slen = pcm_port_pkg::slot_len(lcfg_q.gain_en);
   assign in_rx = framed_q && len_q && (cur >= off) && (cur < off + slen);

   always_ff @(negedge link_bclk or posedge rst)
   begin
      if (rst)
      begin
         lcfg_m_q <= pcm_port_pkg::CFG_RESET;
         lcfg_q <= pcm_port_pkg::CFG_RESET;
         len_m_q <= 1'b0;
         len_q <= 1'b0;
      end
      else
      begin
         lcfg_m_q <= cfg_q;
         lcfg_q <= lcfg_m_q;
         len_m_q <= en_s_q;
         len_q <= len_m_q;
      end
   end

   always_ff @(negedge link_bclk or posedge rst)
   begin
      if (rst)
      begin
         sync_prev_q <= 1'b0;
         framed_q <= 1'b0;
         have_len_q <= 1'b0;
         pos_q <= '0;
         flen_q <= '0;
      end
      else
      begin
         sync_prev_q <= pcm_sync_i;
         pos_q <= cur;
         if (start)
         begin
            framed_q <= 1'b1;
            have_len_q <= framed_q;
            flen_q <= pos_q + 1'b1;
         end
      end
   end

   always_ff @(negedge link_bclk or posedge rst)
   begin
      if (rst)
      begin
         rx_sh_q <= '0;
         rx_word_q <= '0;
         rx_tgl_q <= 1'b0;
      end
      else if (in_rx)
      begin
         rx_sh_q <= {rx_sh_q[14:0], pcm_in};
         if (cur == off + slen - 1'b1)
         begin
            // a 13-bit sample is left aligned with zero gain bits
            rx_word_q <= lcfg_q.gain_en ? {rx_sh_q[14:0], pcm_in}
                                        : {rx_sh_q[11:0], pcm_in, 3'h0};
            rx_tgl_q <= ~rx_tgl_q;
         end
      end
   end

   // the staged bit is prepared half a bit early and launched on the rise
   always_ff @(negedge link_bclk or posedge rst)
   begin
      if (rst)
      begin
         tx_sh_q <= '0;
         stage_oe_q <= 1'b0;
         tx_tgl_q <= 1'b0;
      end
      else if (framed_q && len_q && (nxt == off))
      begin
         tx_sh_q <= tx_hold_q;
         stage_oe_q <= 1'b1;
         tx_tgl_q <= ~tx_tgl_q;
      end
      else if (stage_oe_q)
      begin
         tx_sh_q <= {tx_sh_q[14:0], 1'b0};
         // the predicted next bit wraps to zero at frame end, so test the current bit
         if (cur == off + slen - 1'b1)
            stage_oe_q <= 1'b0;
      end
   end

   // ***********************************************
   // link domain: launch on rising edges
   // ***********************************************
   always_ff @(posedge link_bclk or posedge rst)
   begin
      if (rst)
      begin
         pcm_out_o <= 1'b0;
         pcm_out_oe_n <= 1'b1;
      end
      else
      begin
         pcm_out_o <= tx_sh_q[15];
         pcm_out_oe_n <= ~stage_oe_q;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   logic clk_dly_q;
   logic hc_seen_q;
   logic [pcm_port_pkg::DIV_W-1:0] hc_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clk_dly_q <= 1'b0;
         hc_seen_q <= 1'b0;
         hc_q <= '0;
      end
      else
      begin
         clk_dly_q <= clk_q;
         hc_q <= (clk_q ^ clk_dly_q) ? 8'h01 : hc_q + 1'b1;
         if (clk_q ^ clk_dly_q)
            hc_seen_q <= 1'b1;
      end
   end

   property p_half_period;
      @(posedge ref_clk) disable iff (rst)
      ((clk_q ^ clk_dly_q) && hc_seen_q && !cfg_q.slave) |-> hc_q == pcm_port_pkg::BCLK_HALF;
   endproperty
   a_half_period: assert property (p_half_period)
      else $error("master bit clock half period wrong");

   property p_sync_start;
      @(posedge ref_clk) disable iff (rst)
      $rose(sync_q) |-> (fbit_q == '0) && clk_q;
   endproperty
   a_sync_start: assert property (p_sync_start)
      else $error("frame sync did not rise at bit zero");

   property p_sync_long;
      @(posedge ref_clk) disable iff (rst)
      $fell(sync_q) |-> fbit_q == pcm_port_pkg::SYNC_FALL_BIT;
   endproperty
   a_sync_long: assert property (p_sync_long)
      else $error("frame sync not held for two bit clocks");

   property p_pins_input;
      @(posedge ref_clk) disable iff (rst)
      (cfg_taken_q && cfg_q.slave) |=> pcm_clk_oe_n && pcm_sync_oe_n && !clk_q;
   endproperty
   a_pins_input: assert property (p_pins_input)
      else $error("clock or sync driven in slave mode");

   property p_mode_fixed;
      @(posedge ref_clk) disable iff (rst)
      cfg_taken_q |=> $stable(cfg_q) && cfg_taken_q;
   endproperty
   a_mode_fixed: assert property (p_mode_fixed)
      else $error("mode changed after capture");

   property p_rx_deliver;
      @(posedge ref_clk) disable iff (rst)
      rx_edge |=> rx_valid && (rx_data == $past(rx_word_q)) ##1 !rx_valid;
   endproperty
   a_rx_deliver: assert property (p_rx_deliver)
      else $error("received sample not delivered");

   property p_tx_take;
      @(posedge ref_clk) disable iff (rst)
      (tx_pop && fifo_valid) |=> tx_hold_q == $past(fifo_data);
   endproperty
   a_tx_take: assert property (p_tx_take)
      else $error("transmit word not taken from buffer");

   logic [PW-1:0] drv_run_q;

   // a run counter keeps the slot checks short instead of unrolling long repeats
   always_ff @(posedge link_bclk or posedge rst)
   begin
      if (rst)
         drv_run_q <= '0;
      else if (!pcm_out_oe_n)
         drv_run_q <= drv_run_q + 1'b1;
      else
         drv_run_q <= '0;
   end

   property p_slot16;
      @(posedge link_bclk) disable iff (rst)
      (lcfg_q.gain_en && (drv_run_q != '0))
         |-> (pcm_out_oe_n ? (drv_run_q == pcm_port_pkg::SLOT_BITS)
                           : (drv_run_q < pcm_port_pkg::SLOT_BITS));
   endproperty
   a_slot16: assert property (p_slot16)
      else $error("gain slot not sixteen bits long");

   property p_slot13;
      @(posedge link_bclk) disable iff (rst)
      (!lcfg_q.gain_en && (drv_run_q != '0))
         |-> (pcm_out_oe_n ? (drv_run_q == pcm_port_pkg::AUDIO_BITS)
                           : (drv_run_q < pcm_port_pkg::AUDIO_BITS));
   endproperty
   a_slot13: assert property (p_slot13)
      else $error("data out not released after thirteen bits");

   property p_link_gate;
      @(negedge link_bclk) disable iff (rst)
      $rose(stage_oe_q) |-> $past(len_q) && $past(framed_q);
   endproperty
   a_link_gate: assert property (p_link_gate)
      else $error("slot started without an enabled connection");
endmodule // pcm_voice_port
`default_nettype wire

// ===== include/pcm_port_pkg.sv
// Function
// - one voice channel over four wires: data in, data out, bit clock, frame sync
// - at most one voice connection uses the port; others go elsewhere
// - samples pass straight between port and baseband, no protocol layer
// - after reset the port is master and makes clock and sync
// - master drives a 256kHz bit clock and an 8kHz long frame sync
// - master issues one sync per sample, 8kHz period, marking sample start
// - sync rise marks the MSB; sync stays high two bit clocks or more
// - master never generates short frame sync
// - data launched on rising bit clock edge, captured on falling edge
// - in slave mode output moves on received rising edges, input on falling
// - slave mode comes from a stored configuration value, not a pin
// - bit clock runs at least eight times bits per sample in kHz
// - samples are 13-bit linear PCM, most significant bit first
// - optional three gain bits follow the audio, giving a 16-bit slot
// - slave mode supports several time-multiplexed channels on one link
// - data out goes high impedance once the sample slot has ended
`default_nettype none
package pcm_port_pkg;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int unsigned REF_CLK_HZ = 100_000_000;
   localparam int unsigned MASTER_BCLK_HZ = 256_000;
   localparam int unsigned FRAME_HZ = 8_000;
   localparam int unsigned BCLK_HALF_CYC = REF_CLK_HZ / (2 * MASTER_BCLK_HZ);
   localparam int unsigned BITS_PER_FRAME = MASTER_BCLK_HZ / FRAME_HZ;
   localparam int unsigned SYNC_HIGH_BITS = 2;
   localparam int unsigned DIV_W = 8;
   localparam int unsigned FBIT_W = 5;
   localparam int unsigned POS_W = 7;
   localparam logic [DIV_W-1:0] BCLK_HALF = DIV_W'(BCLK_HALF_CYC);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);
   localparam logic [FBIT_W-1:0] FBIT_LAST = FBIT_W'(BITS_PER_FRAME - 1);
   localparam logic [FBIT_W-1:0] SYNC_FALL_BIT = FBIT_W'(SYNC_HIGH_BITS);
   // ***********************************************
   // sample format
   // ***********************************************
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [POS_W-1:0] AUDIO_BITS = 7'h0d;
   localparam logic [POS_W-1:0] SLOT_BITS = 7'h10;
   typedef logic [SAMPLE_W-1:0] sample_t;
   typedef struct packed {
      logic slave;
      logic gain_en;
      logic [1:0] slot_idx;
   } voice_cfg_t;
   localparam voice_cfg_t CFG_RESET = voice_cfg_t'(4'h0);
   function automatic logic [POS_W-1:0] slot_len(input logic gain_en);
      slot_len = gain_en ? SLOT_BITS : AUDIO_BITS;
   endfunction
   function automatic logic [POS_W-1:0] slot_off(input logic [1:0] idx);
      slot_off = {1'b0, idx, 4'h0};
   endfunction
endpackage
`default_nettype wire

// ===== verilog/sample_fifo.sv
`default_nettype none
module sample_fifo
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // ready is registered so that back-pressure reaches the source cleanly
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_d;
         in_ready <= (cnt_d != (AW+1)'(DEPTH));
      end
   end
endmodule // sample_fifo
`default_nettype wire

// ===== bench/pcm_codec_model.sv
`default_nettype none
module pcm_codec_model
(
   // pads as the codec sees them
   input wire logic bclk,
   input wire logic sync,
   input wire logic dout_line,
   input wire logic dout_oe_n,
   output var logic clk_drv,
   output var logic sync_drv,
   output var logic din,
   // slot placement and the word the codec sends
   input wire logic [6:0] off,
   input wire logic [6:0] len,
   input wire logic [15:0] send_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************
   // state
   // ************************************************
   localparam int FRAME_BITS = 64;
   logic [15:0] sh;
   logic [15:0] got_word;
   logic [15:0] got_q[$];
   logic sync_prev;
   int pos;
   int npos;
   int cur_drive;
   int last_drive;
   int tot_drive;
   initial
   begin
      clk_drv = 1'b0;
      sync_drv = 1'b0;
      din = 1'b0;
      sync_prev = 1'b0;
      sh = 16'h0000;
      got_word = 16'h0000;
      pos = 1000;
      cur_drive = 0;
      last_drive = 0;
      tot_drive = 0;
   end
   // ************************************************
   // codec as master: clock stands still between bursts
   // ************************************************
   task automatic run_frames(input int n);
      for (int b = 0; b < n * FRAME_BITS; b++)
      begin
         clk_drv = 1'b1;
         sync_drv = (b % FRAME_BITS) < 2;
         #6;
         clk_drv = 1'b0;
         #6;
      end
      sync_drv = 1'b0;
   endtask
   // ************************************************
   // capture on falling edges, long sync start is position 0
   // ************************************************
   always @(negedge bclk)
   begin
      if (sync && !sync_prev)
      begin
         last_drive = cur_drive;
         cur_drive = 0;
         pos = 0;
      end
      else
         pos++;
      sync_prev = sync;
      if (!dout_oe_n)
      begin
         cur_drive++;
         tot_drive++;
      end
      if (pos >= int'(off) && pos < int'(off) + int'(len))
      begin
         sh = {sh[14:0], dout_line};
         if (pos == int'(off) + int'(len) - 1)
         begin
            got_word = (len == 7'h10) ? sh : {sh[12:0], 3'h0};
            got_q.push_back(got_word);
         end
      end
   end
   // ************************************************
   // launch on rising edges; outside the slot the line is driven low
   // ************************************************
   always @(posedge bclk)
   begin
      #1;
      npos = (sync && !sync_prev) ? 0 : pos + 1;
      if (npos >= int'(off) && npos < int'(off) + int'(len))
         din = send_word[15 - (npos - int'(off))];
      else
         din = 1'b0;
   end
endmodule // pcm_codec_model
`default_nettype wire

// ===== bench/pcm_voice_port_tb.sv
`default_nettype none
module pcm_voice_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************
   // signals
   // ************************************************
   typedef struct packed {
      logic gain;
      logic [1:0] slot;
      logic [15:0] tx;
      logic [15:0] cw;
      logic [15:0] exp_out;
      logic [15:0] exp_rx;
   } row_t;
   logic ref_clk;
   logic rst;
   pcm_port_pkg::voice_cfg_t cfg_store;
   logic voice_link_en;
   pcm_port_pkg::sample_t tx_data;
   logic tx_valid;
   logic tx_ready;
   pcm_port_pkg::sample_t rx_data;
   logic rx_valid;
   logic slave_mode;
   logic pcm_in;
   logic pcm_out_o;
   logic pcm_out_oe_n;
   logic pcm_sync_o;
   logic pcm_sync_oe_n;
   logic pcm_clk_o;
   logic pcm_clk_oe_n;
   logic codec_clk;
   logic codec_sync;
   logic clk_pad;
   logic sync_pad;
   logic out_pad;
   logic [6:0] mod_off;
   logic [6:0] mod_len;
   logic [15:0] mod_word;
   pcm_port_pkg::sample_t rx_last;
   int error_cnt = 0;
   int comparisons = 0;
   int j;
   int n;
   longint t0;
   localparam longint BIT_NS = 20 * pcm_port_pkg::BCLK_HALF_CYC;
   row_t rows [4] = '{
      '{1'b1, 2'h0, 16'ha5c3, 16'h3c5a, 16'ha5c3, 16'h3c5a},
      '{1'b0, 2'h1, 16'hf00f, 16'h0ff7, 16'hf008, 16'h0ff0},
      '{1'b1, 2'h3, 16'h8001, 16'h7ffe, 16'h8001, 16'h7ffe},
      '{1'b0, 2'h2, 16'h1235, 16'hfedb, 16'h1230, 16'hfed8}};
   // pads are pulled down wherever nobody drives them
   assign clk_pad = !pcm_clk_oe_n ? pcm_clk_o : codec_clk;
   assign sync_pad = !pcm_sync_oe_n ? pcm_sync_o : codec_sync;
   assign out_pad = !pcm_out_oe_n && pcm_out_o;
   pcm_voice_port uut (.ref_clk(ref_clk), .rst(rst), .link_bclk(clk_pad), .cfg_store(cfg_store),
      .voice_link_en(voice_link_en), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .slave_mode(slave_mode), .pcm_in(pcm_in),
      .pcm_out_o(pcm_out_o), .pcm_out_oe_n(pcm_out_oe_n), .pcm_sync_i(sync_pad),
      .pcm_sync_o(pcm_sync_o), .pcm_sync_oe_n(pcm_sync_oe_n), .pcm_clk_o(pcm_clk_o),
      .pcm_clk_oe_n(pcm_clk_oe_n));
   pcm_codec_model codec (.bclk(clk_pad), .sync(sync_pad), .dout_line(out_pad),
      .dout_oe_n(pcm_out_oe_n), .clk_drv(codec_clk), .sync_drv(codec_sync), .din(pcm_in),
      .off(mod_off), .len(mod_len), .send_word(mod_word));
   // ************************************************
   // helpers
   // ************************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (rx_valid === 1'b1)
         rx_last <= rx_data;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // config is a strap captured once, so each mode needs its own reset
   task automatic do_reset(input pcm_port_pkg::voice_cfg_t cfg);
      @(posedge ref_clk);
      rst <= 1'b1;
      cfg_store <= cfg;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   // leaves valid high; the caller lowers it
   task automatic push(input pcm_port_pkg::sample_t w, input int cnt);
      repeat (cnt)
      begin
         tx_data <= w;
         tx_valid <= 1'b1;
         @(posedge ref_clk);
         while (tx_ready !== 1'b1) @(posedge ref_clk);
      end
   endtask
   initial
   begin
      #900_000;
      error_cnt++;
      complete_run();
   end
   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      rst = 1'b0;
      cfg_store = pcm_port_pkg::CFG_RESET;
      voice_link_en = 1'b1;
      tx_data = 16'h0000;
      tx_valid = 1'b0;
      rx_last = 16'h0000;
      mod_off = 7'h00;
      mod_len = 7'h10;
      mod_word = 16'h0000;
      foreach (rows[i])
      begin
         mod_off <= {1'b0, rows[i].slot, 4'h0};
         mod_len <= rows[i].gain ? 7'h10 : 7'h0d;
         mod_word <= rows[i].cw;
         do_reset(pcm_port_pkg::voice_cfg_t'({1'b1, rows[i].gain, rows[i].slot}));
         check(32'(slave_mode), 32'h1);
         check(32'({pcm_clk_oe_n, pcm_sync_oe_n}), 32'h3);
         push(rows[i].tx, 4);
         tx_valid <= 1'b0;
         codec.run_frames(4);
         repeat (10) @(posedge ref_clk);
         check(32'(codec.got_word), 32'(rows[i].exp_out));
         check(32'(rx_last), 32'(rows[i].exp_rx));
         check(32'(codec.last_drive), 32'(mod_len));
      end
      // connection disabled: no slot is driven
      voice_link_en <= 1'b0;
      n = codec.tot_drive;
      push(16'hffff, 2);
      tx_valid <= 1'b0;
      codec.run_frames(3);
      check(32'(codec.tot_drive - n), 32'h0);
      @(posedge ref_clk);
      voice_link_en <= 1'b1;
      // fill until refused with the link stopped, then drain in order
      mod_off <= 7'h00;
      mod_len <= 7'h10;
      do_reset(pcm_port_pkg::voice_cfg_t'(4'hc));
      for (int i = 0; i < 16; i++) push(16'h8001 + 16'(i) * 16'h0111, 1);
      tx_data <= 16'hdead;
      repeat (3) @(posedge ref_clk);
      check(32'(tx_ready), 32'h0);
      tx_valid <= 1'b0;
      codec.got_q.delete();
      codec.run_frames(20);
      @(posedge ref_clk);
      check(32'(tx_ready), 32'h1);
      j = 0;
      while (j < codec.got_q.size() && codec.got_q[j] === 16'h0000) j++;
      for (int i = 0; i < 16; i++)
         check(32'(codec.got_q[j + i]), 32'(16'h8001 + 16'(i) * 16'h0111));
      check(32'(codec.got_q[j + 16]), 32'h0);
      // master after reset: clock, long sync, data
      mod_word <= 16'h5a3c;
      do_reset(pcm_port_pkg::voice_cfg_t'(4'h4));
      check(32'(slave_mode), 32'h0);
      check(32'({pcm_clk_oe_n, pcm_sync_oe_n}), 32'h0);
      push(16'hc3a5, 4);
      tx_valid <= 1'b0;
      @(posedge pcm_clk_o);
      t0 = $time;
      @(posedge pcm_clk_o);
      check(32'($time - t0), 32'(BIT_NS));
      @(posedge pcm_sync_o);
      t0 = $time;
      #1;
      check(32'(pcm_clk_o), 32'h1);
      @(negedge pcm_sync_o);
      check(32'($time - t0), 32'(BIT_NS * pcm_port_pkg::SYNC_HIGH_BITS));
      @(posedge pcm_sync_o);
      check(32'($time - t0), 32'(BIT_NS * pcm_port_pkg::BITS_PER_FRAME));
      n = codec.got_q.size() + 3;
      while (codec.got_q.size() < n) @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
      check(32'(codec.got_word), 32'hc3a5);
      check(32'(rx_last), 32'h5a3c);
      check(32'(codec.last_drive), 32'h10);
      complete_run();
   end
endmodule // pcm_voice_port_tb
`default_nettype wire
